// [design/rpsm_consts.svh]
// Register offsets, field positions, reset values and widths of the pin-select map
`ifndef RPSM_CONSTS_SVH
`define RPSM_CONSTS_SVH
`define RPSM_OFF_MOD_SEL 12'h000
`define RPSM_OFF_CAR_SEL 12'h004
`define RPSM_OFF_MAP01 12'h008
`define RPSM_OFF_MAP23 12'h00c
`define RPSM_OFF_MAP5 12'h010
`define RPSM_OFF_MAP67 12'h014
`define RPSM_OFF_MAP89 12'h018
`define RPSM_OFF_MAP1011 12'h01c
`define RPSM_LO_LSB 0
`define RPSM_HI_LSB 8
`define RPSM_FIELD_W 6
`define RPSM_SEL_RST 6'h3f
`define RPSM_MAP_RST 6'h00
`define RPSM_FN_NONE 6'h00
`define RPSM_ADDR_W 12
`define RPSM_NUM_PINS 12
`define RPSM_NUM_FN 64
`endif

// [design/rpsm_pkg.sv]
// Types shared by the pin-select map
package rpsm_pkg;
    typedef logic [5:0] rpsm_field_t;
    typedef struct packed {
        logic paddr_ok;
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } rpsm_apb_req_t;
    typedef struct packed {
        rpsm_field_t mod_sel;
        rpsm_field_t car2_sel;
        rpsm_field_t car1_sel;
        rpsm_field_t [11:0] pin_fn;
        logic [31:0] prdata;
        logic pslverr;
        logic pready;
        logic modulator_data_in;
        logic carrier_one_in;
        logic carrier_two_in;
        logic [11:0] pin_out;
        logic [11:0] pin_out_en;
    } rpsm_state_t;
endpackage : rpsm_pkg

// [design/rpsm_in_pick.sv]
// Picks one remappable pin level by a select code, inactive low when unmatched
`timescale 1ns/1ns
module rpsm_in_pick #(
    parameter int NUM_PINS = 12
) (
    input wire logic [5:0] sel,
    input wire logic [NUM_PINS-1:0] pins,
    output logic level
);
    always_comb begin
        level = 1'b0;
        if (32'(sel) < NUM_PINS) begin
            level = pins[sel[3:0]];
        end
    end
endmodule : rpsm_in_pick

// [design/rpsm_out_pick.sv]
// Picks the peripheral output for one pin by function number
`timescale 1ns/1ns
`include "rpsm_consts.svh"
module rpsm_out_pick #(
    parameter int NUM_FN = 64
) (
    input wire logic [5:0] fn,
    input wire logic [NUM_FN-1:0] fn_out,
    output logic level,
    output logic en
);
    always_comb begin
        en = (fn != `RPSM_FN_NONE);
        level = en ? fn_out[fn] : 1'b0;
    end
endmodule : rpsm_out_pick

// [design/rpsm_map.sv]
// Remappable pin-select map: input selects and output maps behind APB
//
// Function
// R01 - Unimplemented bits read zero; writes to them are ignored.
// R02 - Modulator data input comes from the pin chosen by select bits 5..0.
// R03 - Carrier two input comes from the pin chosen by bits 13..8.
// R04 - Carrier one input comes from the pin chosen by bits 5..0.
// R05 - Input select fields are read/write and reset to all ones.
// R06 - Output map fields are read/write and reset to zero.
// R07 - Pin 0 driven by function number in map register 0 bits 5..0.
// R08 - Pin 1 driven by function number in map register 0 bits 13..8.
// R09 - Pins 2 and 3 from low and high fields of map register 1.
// R10 - Map register 2 holds only pin 5 field; pin 4 has none.
// R11 - Pins 6 and 7 from low and high fields of map register 3.
// R12 - Pins 8 and 9 from low and high fields of map register 4.
// R13 - Pins 10 and 11 from low and high fields of map register 5.
// R14 - Function number zero connects nothing; pin stays under port control.
// R15 - Select code matching no pin leaves the input held low.
`timescale 1ns/1ns
`include "rpsm_consts.svh"
module rpsm_map #(
    parameter int NUM_PINS = `RPSM_NUM_PINS,
    parameter int NUM_FN = `RPSM_NUM_FN
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [11:0] pin_in,
    input wire logic [NUM_FN-1:0] periph_out,
    output logic [11:0] pin_out,
    output logic [11:0] pin_out_en,
    output logic modulator_data_in,
    output logic carrier_one_in,
    output logic carrier_two_in
);
    rpsm_pkg::rpsm_state_t state_reg;
    rpsm_pkg::rpsm_state_t state_next;
    logic mod_lvl;
    logic car1_lvl;
    logic car2_lvl;
    logic [11:0] out_lvl;
    logic [11:0] out_en;

    rpsm_in_pick #(.NUM_PINS(NUM_PINS)) u_mod (
        .sel(state_reg.mod_sel),
        .pins(pin_in),
        .level(mod_lvl)
    );
    rpsm_in_pick #(.NUM_PINS(NUM_PINS)) u_car1 (
        .sel(state_reg.car1_sel),
        .pins(pin_in),
        .level(car1_lvl)
    );
    rpsm_in_pick #(.NUM_PINS(NUM_PINS)) u_car2 (
        .sel(state_reg.car2_sel),
        .pins(pin_in),
        .level(car2_lvl)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 12; gi++) begin : g_out
            rpsm_out_pick #(.NUM_FN(NUM_FN)) u_pick (
                .fn(state_reg.pin_fn[gi]),
                .fn_out(periph_out),
                .level(out_lvl[gi]),
                .en(out_en[gi])
            );
        end
    endgenerate

    function automatic logic [31:0] pack2(input logic [5:0] hi, input logic [5:0] lo);
        pack2 = {16'h0000, 2'b00, hi, 2'b00, lo}; // R01
    endfunction : pack2

    logic wr;
    logic rd;
    always_comb begin
        state_next = state_reg;
        // Zero-wait slave: access phase always completes at once
        state_next.pready = psel & ~penable;
        state_next.pslverr = 1'b0;
        wr = psel & penable & pwrite;
        rd = psel & ~penable & ~pwrite;
        if (wr) begin
            case (paddr)
                `RPSM_OFF_MOD_SEL: state_next.mod_sel = pwdata[5:0]; // R02 R05 R01
                `RPSM_OFF_CAR_SEL: begin
                    state_next.car1_sel = pwdata[5:0]; // R04
                    state_next.car2_sel = pwdata[13:8]; // R03
                end
                `RPSM_OFF_MAP01: begin
                    state_next.pin_fn[0] = pwdata[5:0]; // R07
                    state_next.pin_fn[1] = pwdata[13:8]; // R08
                end
                `RPSM_OFF_MAP23: begin
                    state_next.pin_fn[2] = pwdata[5:0]; // R09
                    state_next.pin_fn[3] = pwdata[13:8]; // R09
                end
                `RPSM_OFF_MAP5: state_next.pin_fn[5] = pwdata[13:8]; // R10
                `RPSM_OFF_MAP67: begin
                    state_next.pin_fn[6] = pwdata[5:0]; // R11
                    state_next.pin_fn[7] = pwdata[13:8]; // R11
                end
                `RPSM_OFF_MAP89: begin
                    state_next.pin_fn[8] = pwdata[5:0]; // R12
                    state_next.pin_fn[9] = pwdata[13:8]; // R12
                end
                `RPSM_OFF_MAP1011: begin
                    state_next.pin_fn[10] = pwdata[5:0]; // R13
                    state_next.pin_fn[11] = pwdata[13:8]; // R13
                end
                default: state_next.pslverr = 1'b0;
            endcase
        end
        // Unmapped addresses read zero and never error
        state_next.prdata = 32'h0000_0000;
        if (rd) begin
            case (paddr)
                `RPSM_OFF_MOD_SEL: state_next.prdata = pack2(6'h00, state_reg.mod_sel);
                `RPSM_OFF_CAR_SEL: state_next.prdata = pack2(state_reg.car2_sel, state_reg.car1_sel);
                `RPSM_OFF_MAP01: state_next.prdata = pack2(state_reg.pin_fn[1], state_reg.pin_fn[0]);
                `RPSM_OFF_MAP23: state_next.prdata = pack2(state_reg.pin_fn[3], state_reg.pin_fn[2]);
                `RPSM_OFF_MAP5: state_next.prdata = pack2(state_reg.pin_fn[5], 6'h00); // R10
                `RPSM_OFF_MAP67: state_next.prdata = pack2(state_reg.pin_fn[7], state_reg.pin_fn[6]);
                `RPSM_OFF_MAP89: state_next.prdata = pack2(state_reg.pin_fn[9], state_reg.pin_fn[8]);
                `RPSM_OFF_MAP1011: state_next.prdata = pack2(state_reg.pin_fn[11], state_reg.pin_fn[10]);
                default: state_next.prdata = 32'h0000_0000;
            endcase
        end else if (psel & penable) begin
            state_next.prdata = state_reg.prdata;
        end
        // Pin 4 has no map field, so it never carries a peripheral output
        state_next.pin_fn[4] = `RPSM_FN_NONE; // R10
        state_next.modulator_data_in = mod_lvl; // R02 R15
        state_next.carrier_one_in = car1_lvl; // R04 R15
        state_next.carrier_two_in = car2_lvl; // R03 R15
        state_next.pin_out = out_lvl;
        // Enable low while the map drives the pin
        state_next.pin_out_en = ~out_en; // R14
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
            state_reg.mod_sel <= `RPSM_SEL_RST; // R05
            state_reg.car1_sel <= `RPSM_SEL_RST; // R05
            state_reg.car2_sel <= `RPSM_SEL_RST; // R05
            state_reg.pin_fn <= {12{`RPSM_MAP_RST}}; // R06
            state_reg.pin_out_en <= 12'hfff;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign pin_out = state_reg.pin_out;
    assign pin_out_en = state_reg.pin_out_en;
    assign modulator_data_in = state_reg.modulator_data_in;
    assign carrier_one_in = state_reg.carrier_one_in;
    assign carrier_two_in = state_reg.carrier_two_in;
endmodule : rpsm_map

// [sim/rpsm_map_sva.sv]
// Port checker for the pin-select map
`timescale 1ns/1ns
module rpsm_map_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [11:0] pin_out_en,
    input wire logic modulator_data_in
);
    wire acc_wr = psel && penable && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_hi0; pready && !pwrite |-> (prdata & 32'hffffc0c0) == 32'h0; endproperty
    a_hi0: assert property (p_hi0) else $error("unused bits set");
    property p_map5; pready && !pwrite && paddr == 12'h010 |-> prdata[7:0] == 8'h0; endproperty
    a_map5: assert property (p_map5) else $error("low byte set");
    property p_pin4; pin_out_en[4]; endproperty
    a_pin4: assert property (p_pin4) else $error("pin 4 driven");
    property p_rst; $rose(presetn) |-> pin_out_en == 12'hfff && !modulator_data_in; endproperty
    a_rst: assert property (p_rst) else $error("reset levels");
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no pready");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("pready held");
    property p_err; !pslverr; endproperty
    a_err: assert property (p_err) else $error("pslverr set");
    // Pin output enables may move only just after a write lands
    property p_en; $changed(pin_out_en) |-> $past(acc_wr) || $past(acc_wr, 2); endproperty
    a_en: assert property (p_en) else $error("map moved");
    c_wr: cover property (pready && pwrite);
    c_rd: cover property (pready && !pwrite);
    c_map: cover property ($fell(pin_out_en[0]));
endmodule : rpsm_map_sva

// [sim/tb_top.sv]
// Directed APB bench for the pin-select map
`timescale 1ns/1ns
module tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, md, c1, c2;
    logic [11:0] paddr = 12'h0, pin_in = 12'h0, pin_out, pin_out_en, exp_en, exp_out;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [63:0] periph_out = 64'h0;
    int err_count = 0, comparisons = 0;
    always #20 pclk = ~pclk;
    rpsm_map uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .periph_out(periph_out), .pin_out_en(pin_out_en), .modulator_data_in(md), .carrier_one_in(c1), .carrier_two_in(c2));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) err_count++;
        if (s !== e) $display("unexpected %s expected %h seen %h", nm, e, s);
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait limit here; only the watchdog ends a hung access
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("prdata", e, q);
    endtask : rd
    task test_done;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    initial #100000 begin
        err_count++;
        test_done;
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Index 8 is unmapped: ignores writes, reads zero
        for (int i = 0; i < 9; i++) begin
            rd(12'(4 * i), i == 0 ? 32'h3f : i == 1 ? 32'h3f3f : 32'h0);
            apb(1'b1, 12'(4 * i), 32'hffffffff);
            rd(12'(4 * i), i == 0 ? 32'h3f : i == 4 ? 32'h3f00 : i == 8 ? 32'h0 : 32'h3f3f);
        end
        for (int i = 0; i < 6; i++)
            apb(1'b1, 12'(8 + 4 * i), {18'h0, 6'(2 * i + 2), 2'h0, 6'(2 * i + 1)});
        periph_out <= 64'h5a5ac3c30f0fa5a5;
        repeat (3) @(posedge pclk);
        for (int p = 0; p < 12; p++) begin
            exp_en[p] = p == 4;
            exp_out[p] = p != 4 && periph_out[p + 1];
        end
        chk("en", {20'h0, exp_en}, {20'h0, pin_out_en});
        chk("out", {20'h0, exp_out}, {20'h0, pin_out});
        apb(1'b1, 12'h008, 32'h0);
        repeat (3) @(posedge pclk);
        chk("en01", 32'h3, {30'h0, pin_out_en[1:0]});
        // Function zero must not pass periph_out[0], which is high here
        chk("out01", 32'h0, {30'h0, pin_out[1:0]});
        apb(1'b1, 12'h000, 32'h3);
        apb(1'b1, 12'h004, 32'h0705);
        for (int k = 0; k < 2; k++) begin
            pin_in <= k ? 12'hf77 : 12'h088;
            repeat (3) @(posedge pclk);
            chk("md", {31'h0, pin_in[3]}, {31'h0, md});
            chk("c1", {31'h0, pin_in[5]}, {31'h0, c1});
            chk("c2", {31'h0, pin_in[7]}, {31'h0, c2});
        end
        // All pins high, so any wrong pick would show as a one
        pin_in <= 12'hfff;
        apb(1'b1, 12'h000, 32'hc);
        apb(1'b1, 12'h004, 32'h3f0c);
        repeat (3) @(posedge pclk);
        chk("md", 32'h0, {31'h0, md});
        chk("c1", 32'h0, {31'h0, c1});
        chk("c2", 32'h0, {31'h0, c2});
        // Reset in mid-run must restore selects and maps
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h004, 32'h3f3f);
        rd(12'h01c, 32'h0);
        chk("en_rst", 32'hfff, {20'h0, pin_out_en});
        chk("md_rst", 32'h0, {31'h0, md});
        test_done;
    end
endmodule : tb_top
bind rpsm_map rpsm_map_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_out_en(pin_out_en),
    .modulator_data_in(modulator_data_in));
